// File: src/flash_layout_option_bits.sv
// program flash array with option fetch, sector guard and access engine
`timescale 1ns/1ps
`default_nettype none
`include "flash_layout_regs.svh"

module flash_layout_option_bits #(
  parameter int FLASH_BYTES  = `FL_LARGEST_BYTES,
  parameter int ERASE_CYCLES = (`FL_ERASE_TIME_NS + `FL_CLK_PERIOD_NS - 1) / `FL_CLK_PERIOD_NS,
  parameter int XTAL_CYCLES  = `FL_XTAL_RST_CYC
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic                          cpu_req_i,
  input  wire flash_layout_pkg::fl_op_t      cpu_op_i,
  input  wire logic                          cpu_info_i,
  input  wire logic [`FL_ADDR_W-1:0]         cpu_addr_i,
  input  wire logic [7:0]                    cpu_wdata_i,
  output logic                               cpu_ack_o,
  input  wire logic                          dbg_req_i,
  input  wire flash_layout_pkg::fl_op_t      dbg_op_i,
  input  wire logic                          dbg_info_i,
  input  wire logic [`FL_ADDR_W-1:0]         dbg_addr_i,
  input  wire logic [7:0]                    dbg_wdata_i,
  output logic                               dbg_ack_o,
  output logic [7:0]                         rdata_o,
  output logic                               err_o,
  output logic                               busy_o,
  input  wire logic [`FL_MAX_SECTORS-1:0]    sector_protect_i,
  input  wire logic                          osc_xtal_enable_i,
  output logic                               cpu_hold_o,
  output logic                               crystal_off_at_reset_o,
  output logic                               xtal_run_o
);
  import flash_layout_pkg::*;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int AW         = $clog2(FLASH_BYTES);
  localparam int PAGE       = `FL_ROWS_PER_PAGE * `FL_ROW_BYTES;
  localparam int PAGES      = FLASH_BYTES / PAGE;
  localparam int PW         = $clog2(`FL_PAGE_BYTES);
  localparam int PROG_CYC   = (`FL_PROG_TIME_NS + `FL_CLK_PERIOD_NS - 1) / `FL_CLK_PERIOD_NS;
  localparam int IW         = $clog2(`FL_INFO_BYTES);

  // delivered parts come erased; no reset ever touches the arrays
  // initialised at declaration so the write process stays the only driver
  logic [7:0] flash_mem [FLASH_BYTES]    = '{default: `FL_ERASED};
  logic [7:0] info_mem  [`FL_INFO_BYTES] = '{default: `FL_ERASED};

  fl_regs_t              st_r;
  fl_regs_t              st_nxt;
  logic                  mem_we;
  logic [`FL_ADDR_W-1:0] mem_wa;
  logic [7:0]            mem_wd;
  logic                  done;
  logic                  fail;
  logic                  take;
  fl_op_t                r_op;
  logic                  r_info;
  logic [`FL_ADDR_W-1:0] r_addr;
  logic [7:0]            r_wdata;
  logic                  in_range;

  flash_guard_if gif ();

  flash_sector_guard #(
    .FLASH_BYTES (FLASH_BYTES)
  ) u_guard (
    .g (gif.guard)
  );

  // ------------------------------------------------------------
  // request select: debugger wins a tie
  // ------------------------------------------------------------
  assign r_op        = dbg_req_i ? dbg_op_i    : cpu_op_i;
  assign r_info      = dbg_req_i ? dbg_info_i  : cpu_info_i;
  assign r_addr      = dbg_req_i ? dbg_addr_i  : cpu_addr_i;
  assign r_wdata     = dbg_req_i ? dbg_wdata_i : cpu_wdata_i;
  // a request still high in its ack cycle is not taken again
  assign take        = (cpu_req_i || dbg_req_i) && !st_r.ack_cpu && !st_r.ack_dbg
                       && (st_r.state == S_IDLE);
  assign in_range    = r_info ? (32'(r_addr) < `FL_INFO_BYTES)
                              : (32'(r_addr) < FLASH_BYTES);
  assign gif.addr    = r_addr;
  assign gif.protect = sector_protect_i;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_cpu = 1'b0;
    st_nxt.ack_dbg = 1'b0;
    mem_we = 1'b0;
    mem_wa = st_r.addr;
    mem_wd = `FL_ERASED;
    done   = 1'b0;
    fail   = 1'b0;
    if (st_r.cnt != 20'h0) begin
      st_nxt.cnt = st_r.cnt - 20'h1;
    end
    case (st_r.state)
      S_OPT_FETCH: begin
        st_nxt.opt = flash_mem[AW'(`FL_OPT1_ADDR)];
        if (!flash_mem[AW'(`FL_OPT1_ADDR)][`FL_OPT_XTAL_BIT]) begin
          st_nxt.cnt   = 20'(XTAL_CYCLES);
          st_nxt.state = S_XTAL_WAIT;
        end else begin
          st_nxt.state = S_IDLE;
        end
      end
      S_XTAL_WAIT: begin
        if (st_r.cnt <= 20'h1) begin
          st_nxt.state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (take) begin
          st_nxt.grant_dbg = dbg_req_i;
          st_nxt.addr      = r_addr;
          st_nxt.wdata     = r_wdata;
          if (!in_range || r_op == OP_BAD) begin
            done = 1'b1;
            fail = 1'b1;
          end else if (r_op == OP_READ) begin
            st_nxt.rdata = r_info ? info_mem[r_addr[IW-1:0]] : flash_mem[r_addr[AW-1:0]];
            done = 1'b1;
          end else if (r_info || gif.blocked) begin
            // info page, trim bytes included, is never rewritten here
            done = 1'b1;
            fail = 1'b1;
          end else if (r_op == OP_PROG) begin
            st_nxt.cnt   = 20'(PROG_CYC);
            st_nxt.state = S_PROG;
          end else begin
            st_nxt.addr  = {r_addr[`FL_ADDR_W-1:PW], {PW{1'b0}}};
            st_nxt.idx   = 9'h0;
            st_nxt.cnt   = 20'(ERASE_CYCLES);
            st_nxt.state = S_ERASE;
          end
        end
      end
      S_PROG: begin
        if (st_r.cnt <= 20'h1) begin
          // programming only clears bits
          mem_we = 1'b1;
          mem_wd = flash_mem[st_r.addr[AW-1:0]] & st_r.wdata;
          done   = 1'b1;
          st_nxt.state = S_IDLE;
        end
      end
      S_ERASE: begin
        mem_we     = 1'b1;
        mem_wa     = st_r.addr + `FL_ADDR_W'(st_r.idx);
        st_nxt.idx = st_r.idx + 9'h1;
        if (st_r.idx == 9'(`FL_PAGE_BYTES - 1)) begin
          st_nxt.state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (st_r.cnt <= 20'h1) begin
          done = 1'b1;
          st_nxt.state = S_IDLE;
        end
      end
      default: begin
        st_nxt.state = S_OPT_FETCH;
      end
    endcase
    if (done) begin
      st_nxt.err     = fail;
      st_nxt.ack_cpu = !st_nxt.grant_dbg;
      st_nxt.ack_dbg = st_nxt.grant_dbg;
    end
  end

  // ------------------------------------------------------------
  // state and array
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= '{state: S_OPT_FETCH, opt: `FL_OPT_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // array is outside the reset so contents survive every reset
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      flash_mem[mem_wa[AW-1:0]] <= mem_wd;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign cpu_ack_o              = st_r.ack_cpu;
  assign dbg_ack_o              = st_r.ack_dbg;
  assign rdata_o                = st_r.rdata;
  assign err_o                  = st_r.err;
  assign busy_o                 = (st_r.state != S_IDLE);
  assign cpu_hold_o             = (st_r.state == S_OPT_FETCH) || (st_r.state == S_XTAL_WAIT);
  assign crystal_off_at_reset_o = st_r.opt[`FL_OPT_XTAL_BIT];
  // only runs the oscillator; clock selection stays with firmware
  assign xtal_run_o             = !st_r.opt[`FL_OPT_XTAL_BIT] || osc_xtal_enable_i;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence req_prot_s;
    take && r_op != OP_READ && !r_info && in_range && r_op != OP_BAD && gif.blocked;
  endsequence
  sequence refuse_s;
    (cpu_ack_o || dbg_ack_o) && err_o;
  endsequence

  ack_exclusive_a: assert property (!(cpu_ack_o && dbg_ack_o))
    else $error("both acks at once");
  sector_refuse_a: assert property (req_prot_s |=> refuse_s)
    else $error("protected sector not refused");
  opt_applied_a: assert property ($fell(cpu_hold_o) |->
      crystal_off_at_reset_o == flash_mem[AW'(`FL_OPT1_ADDR)][`FL_OPT_XTAL_BIT])
    else $error("option not applied at release");
  xtal_long_rst_a: assert property ((st_r.state == S_OPT_FETCH &&
      !flash_mem[AW'(`FL_OPT1_ADDR)][`FL_OPT_XTAL_BIT]) |=> cpu_hold_o [*8])
    else $error("reset not lengthened");
  xtal_short_rst_a: assert property ((st_r.state == S_OPT_FETCH &&
      flash_mem[AW'(`FL_OPT1_ADDR)][`FL_OPT_XTAL_BIT]) |=> !cpu_hold_o)
    else $error("reset not shortened");
  trim_stable_a: assert property ($stable(info_mem[`FL_TRIM0_ADDR]) && $stable(info_mem[`FL_TRIM1_ADDR]))
    else $error("trim byte changed");
  erase_page_a: assert property ((st_r.state == S_WAIT && st_nxt.state == S_IDLE) |=>
      flash_mem[st_r.addr[AW-1:0]] == `FL_ERASED &&
      flash_mem[AW'(st_r.addr + `FL_ADDR_W'(`FL_PAGE_BYTES - 1))] == `FL_ERASED)
    else $error("page not erased");
  prog_wait_a: assert property ($rose(st_r.state == S_PROG) |-> (!cpu_ack_o && !dbg_ack_o) [*8])
    else $error("program ended too soon");
  read_latency_a: assert property ((take && r_op == OP_READ && in_range) |=>
      (cpu_ack_o || dbg_ack_o) && !err_o)
    else $error("read not answered");
  page_count_a: assert property (PAGES * `FL_PAGE_BYTES == FLASH_BYTES)
    else $error("size not whole pages");

endmodule : flash_layout_option_bits

`default_nettype wire

// File: src/flash_layout_regs.svh
// constants for the program flash layout, option bytes and timing
`ifndef FLASH_LAYOUT_REGS_SVH
`define FLASH_LAYOUT_REGS_SVH

`define FL_ADDR_W          13
`define FL_PAGE_BYTES      512
`define FL_ROW_BYTES       64
`define FL_ROWS_PER_PAGE   8
`define FL_SECTOR_LARGE    1024
`define FL_SECTOR_SMALL    512
`define FL_LARGEST_BYTES   8192
`define FL_MAX_SECTORS     8
`define FL_INFO_BYTES      64
`define FL_OPT1_ADDR       13'h0001
`define FL_OPT_XTAL_BIT    4
`define FL_TRIM0_ADDR      6'h20
`define FL_TRIM1_ADDR      6'h21
`define FL_ERASED          8'hff
`define FL_OPT_RESET       8'hff
`define FL_CLK_PERIOD_NS   10
`define FL_PROG_TIME_NS    20000
`define FL_ERASE_TIME_NS   10000000
`define FL_XTAL_RST_CYC    1000

`endif

// File: src/flash_layout_pkg.sv
// types shared by the flash layout block
`include "flash_layout_regs.svh"

package flash_layout_pkg;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h2,
    OP_BAD   = 2'h3
  } fl_op_t;

  typedef enum logic [5:0] {
    S_OPT_FETCH = 6'h01,
    S_XTAL_WAIT = 6'h02,
    S_IDLE      = 6'h04,
    S_PROG      = 6'h08,
    S_ERASE     = 6'h10,
    S_WAIT      = 6'h20
  } fl_state_t;

  typedef struct packed {
    fl_state_t              state;
    logic [19:0]            cnt;
    logic [`FL_ADDR_W-1:0]  addr;
    logic [7:0]             wdata;
    logic [8:0]             idx;
    logic [7:0]             opt;
    logic [7:0]             rdata;
    logic                   err;
    logic                   ack_cpu;
    logic                   ack_dbg;
    logic                   grant_dbg;
  } fl_regs_t;

endpackage : flash_layout_pkg

// File: src/flash_guard_if.sv
// signals between the access engine and the sector guard
`timescale 1ns/1ps
`default_nettype none
`include "flash_layout_regs.svh"

interface flash_guard_if;
  logic [`FL_ADDR_W-1:0]      addr;
  logic [`FL_MAX_SECTORS-1:0] protect;
  logic                       blocked;

  modport engine (output addr, output protect, input blocked);
  modport guard  (input addr, input protect, output blocked);
endinterface : flash_guard_if

`default_nettype wire

// File: src/flash_sector_guard.sv
// per-sector write protection lookup
`timescale 1ns/1ps
`default_nettype none
`include "flash_layout_regs.svh"

module flash_sector_guard #(
  parameter int FLASH_BYTES = `FL_LARGEST_BYTES
) (
  flash_guard_if.guard g
);
  import flash_layout_pkg::*;

  // ------------------------------------------------------------
  // sector size depends on array size
  // ------------------------------------------------------------
  localparam int SECTOR = (FLASH_BYTES == `FL_LARGEST_BYTES) ? `FL_SECTOR_LARGE
                                                             : `FL_SECTOR_SMALL;
  localparam int SW     = $clog2(SECTOR);

  logic [`FL_ADDR_W-1:0] sector_idx;

  // sectors and pages are sized independently, so index by sector only
  assign sector_idx = g.addr >> SW;
  assign g.blocked  = (sector_idx < `FL_ADDR_W'(`FL_MAX_SECTORS))
                      ? g.protect[sector_idx[2:0]] : 1'b0;

endmodule : flash_sector_guard

`default_nettype wire

// File: testbench/flash_req_model.sv
// request-side model of the firmware or debugger flash access path
`timescale 1ns/1ps
`default_nettype none
`include "flash_layout_regs.svh"

module flash_req_model #(
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     ack_i,
  input  wire logic [7:0]               rdata_i,
  input  wire logic                     err_i,
  output var  logic                     req_o,
  output var  flash_layout_pkg::fl_op_t op_o,
  output var  logic                     info_o,
  output var  logic [`FL_ADDR_W-1:0]    addr_o,
  output var  logic [7:0]               wdata_o
);
  import flash_layout_pkg::*;

  initial begin
    req_o = 1'b0;
    op_o = OP_READ;
    info_o = 1'b0;
    addr_o = 13'h0aaa;
    wdata_o = 8'h55;
  end

  // gap sets idle cycles before the request: small is prompt, large is slow
  task automatic access(input fl_op_t op, input logic inf, input logic [`FL_ADDR_W-1:0] a,
                        input logic [7:0] wd, input int gap, output logic [7:0] rd, output logic er);
    logic [7:0] w;
    int n;
    repeat (gap) @(negedge clk_sys_i);
    // data worked out first so each line changes once per edge
    w = wd;
    if (!inf && a == 13'h0001) w = wd | 8'hef;
    if (SMALL_PKG && !inf && a == 13'h0001) w[4] = 1'b1;
    if (inf && op != OP_READ) w = 8'hff;
    op_o = op;
    info_o = inf;
    addr_o = a;
    wdata_o = w;
    req_o = 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (ack_i !== 1'b1 && n < 3000);
    // a missing ack hands back unknowns so the caller's compare trips
    rd = (ack_i === 1'b1) ? rdata_i : 8'hxx;
    er = (ack_i === 1'b1) ? err_i : 1'bx;
    @(negedge clk_sys_i);
    // released lines must not keep looking valid
    req_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask : access
endmodule : flash_req_model

`default_nettype wire

// File: testbench/flash_layout_option_bits_tb.sv
// self-checking bench for the flash layout and option bit block
`timescale 1ns/1ps
`default_nettype none
`include "flash_layout_regs.svh"

module flash_layout_option_bits_tb;
  import flash_layout_pkg::*;

  localparam int XTAL = 20;

  logic                        clk_sys_i = 1'b0;
  logic                        rst_i = 1'b1;
  logic [`FL_MAX_SECTORS-1:0]  prot = 8'h00;
  logic                        xen = 1'b0;
  logic                        c_req, d_req, c_inf, d_inf, c_ack, d_ack, err, busy, hold, xoff, xrun;
  fl_op_t                      c_op, d_op;
  logic [`FL_ADDR_W-1:0]       c_addr, d_addr;
  logic [7:0]                  c_wd, d_wd, rdata;
  int                          bad_count = 0;
  int                          cmp_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  flash_layout_option_bits #(.ERASE_CYCLES(600), .XTAL_CYCLES(XTAL)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cpu_req_i(c_req), .cpu_op_i(c_op), .cpu_info_i(c_inf), .cpu_addr_i(c_addr), .cpu_wdata_i(c_wd),
    .cpu_ack_o(c_ack),
    .dbg_req_i(d_req), .dbg_op_i(d_op), .dbg_info_i(d_inf), .dbg_addr_i(d_addr), .dbg_wdata_i(d_wd),
    .dbg_ack_o(d_ack), .rdata_o(rdata), .err_o(err), .busy_o(busy), .sector_protect_i(prot),
    .osc_xtal_enable_i(xen), .cpu_hold_o(hold), .crystal_off_at_reset_o(xoff), .xtal_run_o(xrun));

  flash_req_model cpu_m (.clk_sys_i(clk_sys_i), .ack_i(c_ack), .rdata_i(rdata), .err_i(err), .req_o(c_req),
    .op_o(c_op), .info_o(c_inf), .addr_o(c_addr), .wdata_o(c_wd));
  flash_req_model dbg_m (.clk_sys_i(clk_sys_i), .ack_i(d_ack), .rdata_i(rdata), .err_i(err), .req_o(d_req),
    .op_o(d_op), .info_o(d_inf), .addr_o(d_addr), .wdata_o(d_wd));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // port 1 is the debugger; expected read data only checked on reads
  task automatic go(input logic p, input fl_op_t op, input logic inf, input logic [12:0] a,
                    input logic [7:0] wd, input logic [7:0] erd, input logic eer);
    logic [7:0] rd;
    logic       er;
    if (p) dbg_m.access(op, inf, a, wd, 1, rd, er);
    else cpu_m.access(op, inf, a, wd, 4, rd, er);
    if (op == OP_READ) chk(16'(rd), 16'(erd));
    chk(16'(er), 16'(eer));
  endtask : go

  // counts edges after release until the cpu is let go
  task automatic do_reset(input int exp_edges);
    int n;
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(16'(hold), 16'h0001);
    chk(16'(busy), 16'h0001);
    rst_i = 1'b0;
    n = 0;
    while (hold !== 1'b0 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(n), 16'(exp_edges));
    chk(16'(busy), 16'h0000);
  endtask : do_reset

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    do_reset(1);
    chk(16'(xoff), 16'h0001);
    chk(16'(xrun), 16'h0000);
    // firmware enable only; selecting the crystal waits 1000 crystal cycles
    xen = 1'b1;
    #1 chk(16'(xrun), 16'h0001);
    $display("test reset_default done");
    go(0, OP_READ, 0, 13'h0001, 8'h00, 8'hff, 0);
    go(1, OP_READ, 0, 13'h1fff, 8'h00, 8'hff, 0);
    go(0, OP_READ, 1, 13'h0020, 8'h00, 8'hff, 0);
    go(1, OP_READ, 1, 13'h0040, 8'h00, 8'hff, 1);
    go(0, OP_BAD, 0, 13'h0010, 8'h00, 8'h00, 1);
    go(0, OP_PROG, 1, 13'h0020, 8'h00, 8'h00, 1);
    go(1, OP_ERASE, 1, 13'h0021, 8'h00, 8'h00, 1);
    $display("test map_read done");
    go(0, OP_PROG, 0, 13'h0001, 8'hef, 8'h00, 0);
    go(1, OP_READ, 0, 13'h0001, 8'h00, 8'hef, 0);
    go(1, OP_PROG, 0, 13'h0100, 8'hf0, 8'h00, 0);
    go(0, OP_PROG, 0, 13'h0100, 8'h3c, 8'h00, 0);
    go(0, OP_READ, 0, 13'h0100, 8'h00, 8'h30, 0);
    $display("test program done");
    xen = 1'b0;
    do_reset(1 + XTAL);
    chk(16'(xoff), 16'h0000);
    chk(16'(xrun), 16'h0001);
    go(0, OP_READ, 0, 13'h0001, 8'h00, 8'hef, 0);
    go(1, OP_READ, 1, 13'h0021, 8'h00, 8'hff, 0);
    $display("test reset_crystal done");
    go(0, OP_PROG, 0, 13'h0200, 8'h00, 8'h00, 0);
    go(0, OP_PROG, 0, 13'h03ff, 8'h00, 8'h00, 0);
    go(1, OP_PROG, 0, 13'h0400, 8'h00, 8'h00, 0);
    go(1, OP_ERASE, 0, 13'h02a0, 8'h00, 8'h00, 0);
    go(0, OP_READ, 0, 13'h0200, 8'h00, 8'hff, 0);
    go(0, OP_READ, 0, 13'h03ff, 8'h00, 8'hff, 0);
    go(0, OP_READ, 0, 13'h0400, 8'h00, 8'h00, 0);
    go(1, OP_READ, 0, 13'h0100, 8'h00, 8'h30, 0);
    $display("test erase done");
    prot = 8'h04;
    go(0, OP_PROG, 0, 13'h0800, 8'h00, 8'h00, 1);
    go(1, OP_ERASE, 0, 13'h0a00, 8'h00, 8'h00, 1);
    go(0, OP_READ, 0, 13'h0800, 8'h00, 8'hff, 0);
    go(0, OP_PROG, 0, 13'h07ff, 8'h00, 8'h00, 0);
    go(1, OP_PROG, 0, 13'h0c00, 8'h00, 8'h00, 0);
    go(0, OP_ERASE, 0, 13'h0400, 8'h00, 8'h00, 0);
    go(1, OP_READ, 0, 13'h0400, 8'h00, 8'hff, 0);
    go(0, OP_READ, 0, 13'h07ff, 8'h00, 8'h00, 0);
    prot = 8'h00;
    $display("test protect done");
    complete_run();
  end

  // the run needs about 18000 cycles; give it a wide margin
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    bad_count++;
    complete_run();
  end
endmodule : flash_layout_option_bits_tb

`default_nettype wire
